// ===== include/srbc_pkg.sv
// Shared constants and carrier types for the reset and boot control block.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package srbc_pkg;

    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] SRBC_OFF_CTRL     = 4'h0;
    localparam logic [3:0] SRBC_OFF_STATUS   = 4'h1;
    localparam logic [3:0] SRBC_OFF_VTOR     = 4'h2;
    localparam logic [3:0] SRBC_OFF_GPIO_CFG = 4'h3;
    localparam logic [3:0] SRBC_OFF_GPIO_FLG = 4'h4;
    localparam logic [3:0] SRBC_OFF_BOOT     = 4'h5;

    // Control register fields
    localparam int SRBC_CTRL_IRQ_LVL_LSB = 0;
    localparam int SRBC_CTRL_RST_LVL_LSB = 2;
    localparam int SRBC_CTRL_RST_EN_BIT  = 4;
    localparam int SRBC_CTRL_CLK_SEL_LSB = 5;

    // Reset values
    localparam logic [6:0]  SRBC_CTRL_RST     = 7'h00;
    localparam logic [31:0] SRBC_VTOR_RST     = 32'h0000_0000;
    localparam logic [31:0] SRBC_VTOR_MASK    = 32'h3fff_fe00;
    localparam logic [31:0] SRBC_RESET_VECTOR = 32'h0000_0000;

    // Protection patterns in the dedicated flash word; values arbitrary
    localparam logic [31:0] SRBC_PAT_LVL1   = 32'h1234_5678;
    localparam logic [31:0] SRBC_PAT_LVL2   = 32'h8765_4321;
    localparam logic [31:0] SRBC_PAT_LVL3   = 32'h4321_8765;
    localparam logic [31:0] SRBC_PAT_NO_ISP = 32'h4e69_7370;

    // Timing: flash controller init and clock period
    localparam int SRBC_INIT_NS     = 200;
    localparam int SRBC_CLK_NS      = 10;
    localparam int SRBC_INIT_CYCLES = (SRBC_INIT_NS + SRBC_CLK_NS - 1) / SRBC_CLK_NS;
    localparam logic [7:0] SRBC_INIT_CNT = 8'(SRBC_INIT_CYCLES);

    localparam int SRBC_NGPIO = 8;

    typedef enum logic [2:0] {
        SRBC_ST_RESET = 3'b000,
        SRBC_ST_INIT  = 3'b001,
        SRBC_ST_BOOT  = 3'b010,
        SRBC_ST_USER  = 3'b011,
        SRBC_ST_ISP   = 3'b100
    } srbc_state_t;

    typedef enum logic [1:0] {
        SRBC_PROT_NONE = 2'b00,
        SRBC_PROT_ONE  = 2'b01,
        SRBC_PROT_TWO  = 2'b10,
        SRBC_PROT_THREE = 2'b11
    } srbc_prot_t;

    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } srbc_bus_t;

    // Access permissions derived from the protection level
    typedef struct packed {
        logic debug_en;
        logic isp_en;
        logic isp_sector0_en;
        logic isp_mass_only;
        logic iap_en;
    } srbc_access_t;

endpackage

// ===== hdl/srbc_rst_sync.sv
// Reset merger: any source asserts at once, release follows the clock.
// Assumes the four sources are asynchronous levels, active high.
`timescale 1ns/10ps
`default_nettype none
module srbc_rst_sync
    import srbc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [3:0] src_in,
    output logic            rst_out
);
    logic       any_src;
    logic [1:0] sync_ff;

    // Any of the four sources, merged before the synchroniser
    assign any_src = |src_in;

    // Asynchronous assert, two-stage synchronous release
    always_ff @(posedge clk_in or posedge any_src) begin
        if (any_src) begin
            sync_ff <= 2'b11;
        end else begin
            sync_ff <= {sync_ff[0], 1'b0};
        end
    end

    assign rst_out = sync_ff[1];
endmodule
`default_nettype wire

// ===== hdl/srbc_top.sv
// Reset, brownout, protection, boot selection and pin interrupt control.
// Assumes one 100 MHz clock standing for the RC clock; pins are asynchronous.
//
// Behaviour
// - Chip reset comes from pin, watchdog, power-on or brownout.
// - Any reset restarts the RC oscillator and flash controller init; the oscillator enable is held high, only flash init restarts.
// - After release the core fetches from address zero.
// - All registers hold reset values when internal reset ends.
// - Brownout has four interrupt thresholds raising an interrupt request.
// - Brownout signal is readable in a status register.
// - Four further brownout thresholds force a chip reset.
// - Protection is active only for specific flash patterns; level three holds from reset until init reads the flash word.
// - In-application programming works at every protection level.
// - Level one blocks debug, allows programming except sector zero.
// - Level two blocks debug, allows only full erase and reprogram.
// - Level three blocks debug and programming, ignores boot request pin.
// - Boot request pin entry can be disabled without protection.
// - Boot loader runs first, then user code or programming handler.
// - Boot request pin low during reset requests programming handler.
// - Interface select pin high picks UART, low picks CAN.
// - CAN handler offers the same commands as UART handler.
// - Vector table offset within lowest 1 GB, 512 byte aligned.
// - Each GPIO may interrupt on level or edge.
// - RC oscillator is the clock source until software selects another.
`timescale 1ns/10ps
`default_nettype none
module srbc_top
    import srbc_pkg::*;
(
    input  wire logic                  MCLK_IN,
    input  wire logic                  SYS_RST_IN,
    input  wire logic                  RESET_PIN_N_IN,
    input  wire logic                  WDT_RST_IN,
    input  wire logic [2:0]            SUPPLY_LEVEL_IN,
    input  wire logic                  BOOT_REQUEST_PIN_IN,
    input  wire logic                  BOOT_INTERFACE_SELECT_PIN_IN,
    input  wire logic [31:0]           PROT_WORD_IN,
    input  wire logic [SRBC_NGPIO-1:0] GPIO_IN,
    input  wire logic [3:0]            REG_ADDR_IN,
    input  wire logic [31:0]           REG_WDATA_IN,
    input  wire logic                  REG_WR_IN,
    input  wire logic                  REG_RD_IN,
    output logic [31:0]                REG_RDATA_OUT,
    output logic                       CHIP_RST_OUT,
    output logic                       RC_OSC_EN_OUT,
    output logic                       FLASH_INIT_OUT,
    output logic                       CORE_RUN_OUT,
    output logic [31:0]                FETCH_ADDR_OUT,
    output logic                       BROWNOUT_IRQ_OUT,
    output logic [1:0]                 CLK_SEL_OUT,
    output logic                       ISP_ACTIVE_OUT,
    output logic                       ISP_USE_UART_OUT,
    output logic                       ISP_USE_CAN_OUT,
    output logic                       DEBUG_EN_OUT,
    output logic                       ISP_EN_OUT,
    output logic                       ISP_SECTOR0_EN_OUT,
    output logic                       ISP_MASS_ONLY_OUT,
    output logic                       IAP_EN_OUT,
    output logic [SRBC_NGPIO-1:0]      GPIO_IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // State carrier
    typedef struct packed {
        srbc_state_t             state;
        logic [7:0]              cnt;
        logic [6:0]              ctrl;
        logic [31:0]             vtor;
        logic [SRBC_NGPIO-1:0]   gpio_edge;
        logic [SRBC_NGPIO-1:0]   gpio_en;
        logic [SRBC_NGPIO-1:0]   gpio_flag;
        logic [SRBC_NGPIO-1:0]   gpio_prev;
        logic [SRBC_NGPIO-1:0]   gpio_s1;
        logic [SRBC_NGPIO-1:0]   gpio_s2;
        logic [1:0]              boot_s1;
        logic [1:0]              boot_s2;
        logic [2:0]              sup_s1;
        logic [2:0]              sup_s2;
        logic                    boot_req;
        logic                    boot_uart;
        srbc_prot_t              prot;
        logic                    no_isp_pin;
        logic [31:0]             rdata;
    } srbc_regs_t;

    srbc_regs_t cur_ff;
    srbc_regs_t nxt_ff;
    logic       chip_rst;
    logic       bod_rst;
    logic       bod_irq;
    logic       por_rst;
    srbc_access_t acc;

    ////////////////////////////////////////////////////////////////////////
    // Protection decode; only exact patterns count as protected
    function automatic srbc_prot_t prot_decode(input logic [31:0] w);
        case (w)
            SRBC_PAT_LVL1: prot_decode = SRBC_PROT_ONE;
            SRBC_PAT_LVL2: prot_decode = SRBC_PROT_TWO;
            SRBC_PAT_LVL3: prot_decode = SRBC_PROT_THREE;
            default:       prot_decode = SRBC_PROT_NONE;
        endcase
    endfunction

    // Supply at or below threshold: level index 0..3 against a 3-bit supply code
    function automatic logic below_level(input logic [2:0] sup, input logic [1:0] lvl);
        below_level = ({1'b0, sup} <= {2'b00, lvl});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Brownout; reset loads the highest supply code, 3'b111
    assign bod_irq = below_level(cur_ff.sup_s2, cur_ff.ctrl[SRBC_CTRL_IRQ_LVL_LSB +: 2]);
    assign bod_rst = cur_ff.ctrl[SRBC_CTRL_RST_EN_BIT]
                   & below_level(cur_ff.sup_s2, cur_ff.ctrl[SRBC_CTRL_RST_LVL_LSB +: 2]);
    assign por_rst = SYS_RST_IN;

    // Reset merger, raw pin and watchdog go straight in
    srbc_rst_sync u_rst (
        .clk_in  (MCLK_IN),
        .src_in  ({~RESET_PIN_N_IN, WDT_RST_IN, por_rst, bod_rst}),
        .rst_out (chip_rst)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access rights per level; in-application calls never gated
    always_comb begin
        acc.iap_en         = 1'b1;
        acc.debug_en       = (cur_ff.prot == SRBC_PROT_NONE);
        acc.isp_en         = (cur_ff.prot != SRBC_PROT_THREE);
        acc.isp_sector0_en = (cur_ff.prot == SRBC_PROT_NONE);
        acc.isp_mass_only  = (cur_ff.prot == SRBC_PROT_TWO);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rdata = 32'h0000_0000;
        // Pin synchronisers; first stage feeds only the second
        nxt_ff.gpio_s1 = GPIO_IN;
        nxt_ff.gpio_s2 = cur_ff.gpio_s1;
        nxt_ff.boot_s1 = {BOOT_REQUEST_PIN_IN, BOOT_INTERFACE_SELECT_PIN_IN};
        nxt_ff.boot_s2 = cur_ff.boot_s1;
        nxt_ff.sup_s1  = SUPPLY_LEVEL_IN;
        nxt_ff.sup_s2  = cur_ff.sup_s1;
        nxt_ff.gpio_prev = cur_ff.gpio_s2;

        // Boot sequencer
        case (cur_ff.state)
            SRBC_ST_RESET: begin
                nxt_ff.state = SRBC_ST_INIT;
                nxt_ff.cnt   = SRBC_INIT_CNT;
            end
            SRBC_ST_INIT: begin
                // Straps and protection word caught while flash initialises
                nxt_ff.boot_req   = ~cur_ff.boot_s2[1];
                nxt_ff.boot_uart  = cur_ff.boot_s2[0];
                nxt_ff.prot       = prot_decode(PROT_WORD_IN);
                nxt_ff.no_isp_pin = (PROT_WORD_IN == SRBC_PAT_NO_ISP);
                if (cur_ff.cnt == 8'h01) begin
                    nxt_ff.state = SRBC_ST_BOOT;
                end
                nxt_ff.cnt = cur_ff.cnt - 8'h01;
            end
            SRBC_ST_BOOT: begin
                // Loader always decides first; pin ignored at level three or if disabled
                if (cur_ff.boot_req && !cur_ff.no_isp_pin
                    && cur_ff.prot != SRBC_PROT_THREE) begin
                    nxt_ff.state = SRBC_ST_ISP;
                end else begin
                    nxt_ff.state = SRBC_ST_USER;
                end
            end
            SRBC_ST_USER: nxt_ff.state = SRBC_ST_USER;
            SRBC_ST_ISP:  nxt_ff.state = SRBC_ST_ISP;
            default:      nxt_ff.state = SRBC_ST_RESET;
        endcase

        // Pin interrupt sensing; set wins over clear
        for (int i = 0; i < SRBC_NGPIO; i++) begin
            if (REG_WR_IN && REG_ADDR_IN == SRBC_OFF_GPIO_FLG && REG_WDATA_IN[i]) begin
                nxt_ff.gpio_flag[i] = 1'b0;
            end
            if (cur_ff.gpio_en[i]) begin
                if (cur_ff.gpio_edge[i]) begin
                    if (cur_ff.gpio_s2[i] && !cur_ff.gpio_prev[i]) begin
                        nxt_ff.gpio_flag[i] = 1'b1;
                    end
                end else if (cur_ff.gpio_s2[i]) begin
                    nxt_ff.gpio_flag[i] = 1'b1;
                end
            end
        end

        // Register writes
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                SRBC_OFF_CTRL:     nxt_ff.ctrl = REG_WDATA_IN[6:0];
                SRBC_OFF_VTOR:     nxt_ff.vtor = REG_WDATA_IN & SRBC_VTOR_MASK;
                SRBC_OFF_GPIO_CFG: begin
                    nxt_ff.gpio_en   = REG_WDATA_IN[SRBC_NGPIO-1:0];
                    nxt_ff.gpio_edge = REG_WDATA_IN[2*SRBC_NGPIO-1:SRBC_NGPIO];
                end
                default: nxt_ff.ctrl = nxt_ff.ctrl;
            endcase
        end

        // Register reads, data the cycle after; unmapped reads zero
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                SRBC_OFF_CTRL:     nxt_ff.rdata = {25'h0, cur_ff.ctrl};
                SRBC_OFF_STATUS:   nxt_ff.rdata = {27'h0, cur_ff.prot, cur_ff.sup_s2[1:0] == 2'b00,
                                                   bod_rst, bod_irq};
                SRBC_OFF_VTOR:     nxt_ff.rdata = cur_ff.vtor;
                SRBC_OFF_GPIO_CFG: nxt_ff.rdata = {16'h0, cur_ff.gpio_edge, cur_ff.gpio_en};
                SRBC_OFF_GPIO_FLG: nxt_ff.rdata = {24'h0, cur_ff.gpio_flag};
                SRBC_OFF_BOOT:     nxt_ff.rdata = {28'h0, cur_ff.state == SRBC_ST_ISP,
                                                   cur_ff.no_isp_pin, cur_ff.boot_uart,
                                                   cur_ff.boot_req};
                default:           nxt_ff.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; every field to a constant under the merged reset
    always_ff @(posedge MCLK_IN or posedge chip_rst) begin
        if (chip_rst) begin
            cur_ff            <= '0;
            cur_ff.state      <= SRBC_ST_RESET;
            cur_ff.ctrl       <= SRBC_CTRL_RST;
            cur_ff.vtor       <= SRBC_VTOR_RST;
            cur_ff.prot       <= SRBC_PROT_THREE;
            cur_ff.boot_s1    <= 2'b11;
            cur_ff.boot_s2    <= 2'b11;
            cur_ff.sup_s1     <= 3'b111;
            cur_ff.sup_s2     <= 3'b111;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign REG_RDATA_OUT      = cur_ff.rdata;
    assign CHIP_RST_OUT       = chip_rst;
    assign RC_OSC_EN_OUT      = 1'b1;
    assign FLASH_INIT_OUT     = (cur_ff.state == SRBC_ST_RESET) || (cur_ff.state == SRBC_ST_INIT);
    assign CORE_RUN_OUT       = (cur_ff.state == SRBC_ST_BOOT) || (cur_ff.state == SRBC_ST_USER)
                              || (cur_ff.state == SRBC_ST_ISP);
    assign FETCH_ADDR_OUT     = (cur_ff.state == SRBC_ST_USER) ? cur_ff.vtor : SRBC_RESET_VECTOR;
    assign BROWNOUT_IRQ_OUT   = bod_irq;
    assign CLK_SEL_OUT        = cur_ff.ctrl[SRBC_CTRL_CLK_SEL_LSB +: 2];
    assign ISP_ACTIVE_OUT     = (cur_ff.state == SRBC_ST_ISP);
    assign ISP_USE_UART_OUT   = ISP_ACTIVE_OUT & cur_ff.boot_uart;
    assign ISP_USE_CAN_OUT    = ISP_ACTIVE_OUT & ~cur_ff.boot_uart;
    assign DEBUG_EN_OUT       = acc.debug_en;
    assign ISP_EN_OUT         = acc.isp_en;
    assign ISP_SECTOR0_EN_OUT = acc.isp_sector0_en;
    assign ISP_MASS_ONLY_OUT  = acc.isp_mass_only;
    assign IAP_EN_OUT         = acc.iap_en;
    assign GPIO_IRQ_OUT       = cur_ff.gpio_flag;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_init_length: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        $rose(cur_ff.state == SRBC_ST_INIT) |-> (cur_ff.state == SRBC_ST_INIT) [*8])
        else $error("init phase too short");
    a_reset_fetch: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        (cur_ff.state == SRBC_ST_BOOT) |-> FETCH_ADDR_OUT == 32'h0000_0000)
        else $error("boot fetch not at zero");
    a_bod_irq_seen: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        REG_RD_IN && REG_ADDR_IN == SRBC_OFF_STATUS |=> REG_RDATA_OUT[0] == $past(bod_irq))
        else $error("brownout status wrong");
    a_lvl3_no_isp: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        cur_ff.prot == SRBC_PROT_THREE |-> !ISP_ACTIVE_OUT && !DEBUG_EN_OUT && !ISP_EN_OUT)
        else $error("level three leaked access");
    a_lvl1_rights: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        cur_ff.prot == SRBC_PROT_ONE |-> !DEBUG_EN_OUT && ISP_EN_OUT && !ISP_SECTOR0_EN_OUT)
        else $error("level one rights wrong");
    a_lvl2_rights: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        cur_ff.prot == SRBC_PROT_TWO |-> !DEBUG_EN_OUT && ISP_MASS_ONLY_OUT)
        else $error("level two rights wrong");
    a_iap_always: assert property (@(posedge MCLK_IN) disable iff (chip_rst) IAP_EN_OUT)
        else $error("iap blocked");
    a_boot_choice: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        cur_ff.state == SRBC_ST_BOOT |=> (ISP_ACTIVE_OUT == (cur_ff.boot_req
            && !cur_ff.no_isp_pin && cur_ff.prot != SRBC_PROT_THREE)))
        else $error("boot choice wrong");
    a_vtor_align: assert property (@(posedge MCLK_IN) disable iff (chip_rst)
        cur_ff.vtor[8:0] == 9'h000 && cur_ff.vtor[31:30] == 2'b00)
        else $error("vector offset misaligned");
    c_isp_uart: cover property (@(posedge MCLK_IN) ISP_USE_UART_OUT);
    c_isp_can:  cover property (@(posedge MCLK_IN) ISP_USE_CAN_OUT);
    c_user_run: cover property (@(posedge MCLK_IN) cur_ff.state == SRBC_ST_USER);
    c_gpio_irq: cover property (@(posedge MCLK_IN) |GPIO_IRQ_OUT);
endmodule
`default_nettype wire

// ===== verification/srbc_partner.sv
// Far-side model: reset pin, watchdog, supply monitor, boot pins, flash word.
// Assumes the bench sets wanted levels; the lines follow one clock edge later.
`timescale 1ns/10ps
`default_nettype none
module srbc_partner
    import srbc_pkg::*;
(
    input  wire logic [46:0] want_in,
    input  wire logic        clk_in,
    output logic [46:0]      pins_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Pins move just after an edge, as real board logic would
    initial pins_out = want_in;
    always @(posedge clk_in) begin
        pins_out <= want_in; // Every pin follows its wanted level at each edge
    end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Bench for the reset and boot control block: boot table, registers, supply, pins.
// Assumes the far-side model delays every pin by one clock edge.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import srbc_pkg::*;
();
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        rst_n = 1'b1;
    logic        wdt = 1'b0;
    logic        req = 1'b1;
    logic        sel = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  sup = 3'h7;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  gpio = 8'h00;
    logic [31:0] prot = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, fetch, v;
    logic [46:0] want, pins;
    logic [1:0]  clk_sel;
    logic [7:0]  gpio_irq, obs;
    logic        chip_rst, osc_en, flash_init, core_run, irq;
    logic        isp_act, uart, can, dbg, isp_en, sec0, mass, in_application_programming;
    int          bad_count = 0;
    int          num_checks = 0;
    // Boot table: flash word, {request, select}, expected and cared-for outputs
    logic [31:0] pw [6] = '{32'h0, SRBC_PAT_LVL1, SRBC_PAT_LVL2, SRBC_PAT_LVL3,
                            SRBC_PAT_NO_ISP, 32'h0};
    logic [1:0]  rs [6] = '{2'b01, 2'b00, 2'b11, 2'b01, 2'b01, 2'b10};
    logic [7:0]  ex [6] = '{8'hdd, 8'ha9, 8'h0b, 8'h01, 8'h11, 8'h1d};
    logic [7:0]  mk [6] = '{8'hff, 8'hff, 8'hfb, 8'hfd, 8'hf1, 8'hff};

    assign want = {rst_n, wdt, sup, req, sel, prot, gpio};
    assign obs = {isp_act, uart, can, dbg, isp_en, sec0, mass, in_application_programming};

    initial forever #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    srbc_partner far (.want_in(want), .clk_in(clk), .pins_out(pins));

    srbc_top uut (
        .MCLK_IN(clk), .SYS_RST_IN(sys_rst), .RESET_PIN_N_IN(pins[46]),
        .WDT_RST_IN(pins[45]), .SUPPLY_LEVEL_IN(pins[44:42]),
        .BOOT_REQUEST_PIN_IN(pins[41]), .BOOT_INTERFACE_SELECT_PIN_IN(pins[40]),
        .PROT_WORD_IN(pins[39:8]), .GPIO_IN(pins[7:0]), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .CHIP_RST_OUT(chip_rst), .RC_OSC_EN_OUT(osc_en), .FLASH_INIT_OUT(flash_init),
        .CORE_RUN_OUT(core_run), .FETCH_ADDR_OUT(fetch), .BROWNOUT_IRQ_OUT(irq),
        .CLK_SEL_OUT(clk_sel), .ISP_ACTIVE_OUT(isp_act), .ISP_USE_UART_OUT(uart),
        .ISP_USE_CAN_OUT(can), .DEBUG_EN_OUT(dbg), .ISP_EN_OUT(isp_en),
        .ISP_SECTOR0_EN_OUT(sec0), .ISP_MASS_ONLY_OUT(mass), .IAP_EN_OUT(in_application_programming),
        .GPIO_IRQ_OUT(gpio_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, s, e);
        end
    endtask

    // One-cycle strobes; a gap edge keeps two writes of a strobe apart
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Bounded wait for the core to start, then for boot to settle
    task automatic waitrun();
        int n;
        n = 0;
        while (core_run !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        if (n == 80) begin
            bad_count++;
            $display("Error %0t: core never started", $time);
        end
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic boot(input int src);
        @(posedge clk);
        case (src)
            0: sys_rst <= 1'b1;
            1: rst_n <= 1'b0;
            default: wdt <= 1'b1;
        endcase
        repeat (3) @(posedge clk);
        #1;
        chk(32'(flash_init), 32'h1);
        chk(32'(core_run), 32'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        rst_n <= 1'b1;
        wdt <= 1'b0;
        waitrun();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        bad_count++;
        results();
    end

    initial begin
        int i;
        int n;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        waitrun();
        for (i = 0; i < 5; i++) begin
            if (i != 1) begin
                rreg(4'(i), v);
                chk(v, 32'h0);
            end
        end
        // Power-on, pin and watchdog reset in turn, each with its own boot pins and protection
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            prot <= pw[i];
            {req, sel} <= rs[i];
            boot(i % 3);
            chk(32'(obs & mk[i]), 32'(ex[i] & mk[i]));
            chk(fetch, SRBC_RESET_VECTOR);
            chk(32'(clk_sel), 32'h0);
            chk(32'(osc_en), 32'h1);
        end
        wreg(SRBC_OFF_VTOR, 32'hffff_ffff);
        rreg(SRBC_OFF_VTOR, v);
        chk(v, 32'h3fff_fe00);
        chk(fetch, 32'h3fff_fe00);
        rreg(4'hf, v);
        chk(v, 32'h0);
        wreg(SRBC_OFF_CTRL, 32'h0000_0060);
        #1;
        chk(32'(clk_sel), 32'h3);
        // Each interrupt threshold: at the level it fires, one above it does not
        for (i = 0; i < 4; i++) begin
            wreg(SRBC_OFF_CTRL, 32'(i));
            sup <= 3'(i);
            repeat (5) @(posedge clk);
            #1;
            chk(32'(irq), 32'h1);
            rreg(SRBC_OFF_STATUS, v);
            chk(v & 32'h1, 32'h1);
            @(posedge clk);
            sup <= 3'(i + 1);
            repeat (5) @(posedge clk);
            #1;
            chk(32'(irq), 32'h0);
        end
        // Reset threshold one: code two is safe, code one forces a chip reset
        wreg(SRBC_OFF_CTRL, 32'h0000_0014);
        sup <= 3'h2;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(chip_rst), 32'h0);
        @(posedge clk);
        sup <= 3'h1;
        n = 0;
        while (chip_rst !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk(32'(chip_rst), 32'h1);
        sup <= 3'h7;
        waitrun();
        rreg(SRBC_OFF_CTRL, v);
        chk(v, 32'h0);
        // Assert lands between edges, release waits for the clock
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        #1;
        chk(32'(chip_rst), 32'h1);
        @(posedge clk);
        wdt <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'(chip_rst), 32'h1);
        waitrun();
        // Pin 0 level, pin 1 edge, pin 2 disabled
        wreg(SRBC_OFF_GPIO_CFG, 32'h0000_0203);
        gpio <= 8'h07;
        repeat (5) @(posedge clk);
        #1;
        chk(32'(gpio_irq), 32'h3);
        wreg(SRBC_OFF_GPIO_FLG, 32'h0000_0003);
        repeat (5) @(posedge clk);
        #1;
        chk(32'(gpio_irq), 32'h1);
        rreg(SRBC_OFF_GPIO_FLG, v);
        chk(v, 32'h1);
        results();
    end
endmodule
`default_nettype wire
